/* hdl/ptc_pkg.sv */
// constants shared by the pixel pipeline test capture block
// assumes one pixel clock domain and a synchronous active-high reset
package ptc_pkg;

  localparam int COLOR_W = 8;
  localparam int DAC_W = 10;
  localparam int PIX_CAP_W = 24;
  localparam int DAC_CAP_W = 30;
  localparam int STAT_CAP_W = 8;

  // stream word: {sync, blank_n, red, green, blue}
  localparam int STREAM_W = 2 + 3 * COLOR_W;
  localparam int FIFO_DEPTH = 8;

  // clocks from palette index out to post-palette value back; arbitrary plain default
  localparam int DAC_LATENCY = 4;
  // tag carried along the delay line: {trigger, sync, blank_n}
  localparam int TAG_W = 3;

  localparam int TRIG_BIT = 7;

  // status capture bit positions
  localparam int STAT_SYNC_BIT = 0;
  localparam int STAT_BLANK_BIT = 1;
  localparam int STAT_PLL_BIT = 2;

  // host read selects
  localparam logic [1:0] SEL_PIX = 2'h0;
  localparam logic [1:0] SEL_DAC = 2'h1;
  localparam logic [1:0] SEL_STAT = 2'h2;

  localparam logic [PIX_CAP_W-1:0] PIX_CAP_RST = 24'h000000;
  localparam logic [DAC_CAP_W-1:0] DAC_CAP_RST = 30'h00000000;
  localparam logic [STAT_CAP_W-1:0] STAT_CAP_RST = 8'h00;

  typedef enum logic [2:0] {
    PH_RED_LO = 3'b000,
    PH_RED_HI = 3'b001,
    PH_GRN_LO = 3'b010,
    PH_GRN_HI = 3'b011,
    PH_BLU_LO = 3'b100,
    PH_BLU_HI = 3'b101
  } ptc_phase_e;

endpackage

/* hdl/ptc_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes a single clock; in_ready comes straight from a flip-flop
module ptc_fifo
  import ptc_pkg::*;
#(
  parameter int WIDTH = STREAM_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0] count_q, count_d;
  logic ready_q, ready_d;
  logic push, pop;

  assign in_ready = ready_q;
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];

  always_comb begin
    push = in_valid & ready_q;
    pop = out_valid & out_ready;
    wr_ptr_d = push ? wr_ptr_q + AW'(1) : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + AW'(1) : rd_ptr_q;
    count_d = count_q + (AW + 1)'(push) - (AW + 1)'(pop);
    // registered ready: full when count reaches depth, so the source truly stalls
    ready_d = (count_d < (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ready_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule

/* hdl/ptc_delay.sv */
// fixed-length shift line, one stage per clock
// assumes the palette behind it has the same fixed latency
module ptc_delay
  import ptc_pkg::*;
#(
  parameter int WIDTH = TAG_W,
  parameter int STAGES = DAC_LATENCY
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] line_q [STAGES];
  logic [WIDTH-1:0] line_d [STAGES];

  assign out_data = line_q[STAGES-1];

  always_comb begin
    line_d[0] = in_data;
    for (int i = 1; i < STAGES; i++) begin
      line_d[i] = line_q[i-1];
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < STAGES; i++) begin
      if (sys_rst) begin
        line_q[i] <= '0;
      end else begin
        line_q[i] <= line_d[i];
      end
    end
  end

endmodule

/* hdl/ptc_top.sv */
// pixel pipeline test capture: trigger detect, pixel/dac/status capture, host readback
// assumes pixels and palette values are on clk; host read strobe is asynchronous
//
// Notes on behaviour
// - trigger edge captures that pixel's red/green/blue
// - trigger polarity rising or falling, selectable
// - captures hold until next qualifying trigger edge
// - pixel capture is 24-bit read-only, 8/colour
// - pixel capture read in three port cycles
// - dac capture loads fixed clocks after pixel
// - dac capture is 30-bit read-only, 10/colour
// - eight-bit mode returns zero upper two bits
// - dac capture read in three or six cycles
// - status capture bits: sync, blank, pll
// - status latched with dac capture, same pixel
// - blanked pixel stores all-zero dac capture
module ptc_top
  import ptc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic trigger_polarity_select,
  input wire logic res_10bit,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [COLOR_W-1:0] pix_red,
  input wire logic [COLOR_W-1:0] pix_green,
  input wire logic [COLOR_W-1:0] pix_blue,
  input wire logic pix_sync,
  input wire logic pix_blank_n,
  input wire logic pipe_stall,
  output logic pal_valid,
  output logic [COLOR_W-1:0] pal_red,
  output logic [COLOR_W-1:0] pal_green,
  output logic [COLOR_W-1:0] pal_blue,
  input wire logic [DAC_W-1:0] dac_red,
  input wire logic [DAC_W-1:0] dac_green,
  input wire logic [DAC_W-1:0] dac_blue,
  input wire logic pll_current_status,
  input wire logic host_rd_n,
  input wire logic [1:0] host_sel,
  output logic [7:0] host_rd_data,
  output logic host_rd_valid
);

  function automatic logic [DAC_W-1:0] dac_fmt(input logic [DAC_W-1:0] v, input logic wide);
    dac_fmt = wide ? v : {2'h0, v[COLOR_W-1:0]};
  endfunction

  function automatic logic [7:0] dac_byte(input logic [DAC_W-1:0] v, input logic hi);
    dac_byte = hi ? {6'h00, v[DAC_W-1:COLOR_W]} : v[COLOR_W-1:0];
  endfunction

  // input stream buffer
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [STREAM_W-1:0] fifo_out_data;

  ptc_fifo #(
    .WIDTH(STREAM_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data({pix_sync, pix_blank_n, pix_red, pix_green, pix_blue}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  logic cur_sync, cur_blank_n;
  logic [COLOR_W-1:0] cur_red, cur_green, cur_blue;
  logic take;

  assign {cur_sync, cur_blank_n, cur_red, cur_green, cur_blue} = fifo_out_data;
  assign fifo_out_ready = ~pipe_stall;
  assign take = fifo_out_valid & ~pipe_stall;

  // trigger detect and pixel capture
  logic prev_bit_q, prev_bit_d;
  logic prev_seen_q, prev_seen_d;
  logic trig;
  logic [PIX_CAP_W-1:0] pix_cap_q, pix_cap_d;
  logic pal_valid_q, pal_valid_d;
  logic [COLOR_W-1:0] pal_red_q, pal_red_d, pal_green_q, pal_green_d, pal_blue_q, pal_blue_d;
  logic [TAG_W-1:0] tag_q, tag_d;

  always_comb begin
    prev_bit_d = prev_bit_q;
    prev_seen_d = prev_seen_q;
    pix_cap_d = pix_cap_q;
    trig = 1'b0;
    pal_valid_d = take;
    pal_red_d = pal_red_q;
    pal_green_d = pal_green_q;
    pal_blue_d = pal_blue_q;
    if (take) begin
      // first pixel after reset has no predecessor, so it cannot trigger
      if (prev_seen_q) begin
        if (trigger_polarity_select) begin
          trig = ~prev_bit_q & cur_red[TRIG_BIT];
        end else begin
          trig = prev_bit_q & ~cur_red[TRIG_BIT];
        end
      end
      prev_bit_d = cur_red[TRIG_BIT];
      prev_seen_d = 1'b1;
      pal_red_d = cur_red;
      pal_green_d = cur_green;
      pal_blue_d = cur_blue;
    end
    if (trig) begin
      pix_cap_d = {cur_red, cur_green, cur_blue};
    end
    tag_d = {trig, cur_sync & take, cur_blank_n & take};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_bit_q <= 1'b0;
      prev_seen_q <= 1'b0;
      pix_cap_q <= PIX_CAP_RST;
      pal_valid_q <= 1'b0;
      pal_red_q <= 8'h00;
      pal_green_q <= 8'h00;
      pal_blue_q <= 8'h00;
      tag_q <= 3'h0;
    end else begin
      prev_bit_q <= prev_bit_d;
      prev_seen_q <= prev_seen_d;
      pix_cap_q <= pix_cap_d;
      pal_valid_q <= pal_valid_d;
      pal_red_q <= pal_red_d;
      pal_green_q <= pal_green_d;
      pal_blue_q <= pal_blue_d;
      tag_q <= tag_d;
    end
  end

  assign pal_valid = pal_valid_q;
  assign pal_red = pal_red_q;
  assign pal_green = pal_green_q;
  assign pal_blue = pal_blue_q;

  // trigger, sync and blank travel alongside the palette lookup
  logic [TAG_W-1:0] tag_late;
  logic late_trig, late_sync, late_blank_n;

  ptc_delay #(
    .WIDTH(TAG_W),
    .STAGES(DAC_LATENCY)
  ) u_delay (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(tag_q),
    .out_data(tag_late)
  );

  assign {late_trig, late_sync, late_blank_n} = tag_late;

  // dac and status capture
  logic [DAC_CAP_W-1:0] dac_cap_q, dac_cap_d;
  logic [STAT_CAP_W-1:0] stat_cap_q, stat_cap_d;

  always_comb begin
    dac_cap_d = dac_cap_q;
    stat_cap_d = stat_cap_q;
    if (late_trig) begin
      if (late_blank_n) begin
        dac_cap_d = {dac_fmt(dac_red, res_10bit), dac_fmt(dac_green, res_10bit),
                     dac_fmt(dac_blue, res_10bit)};
      end else begin
        dac_cap_d = '0;
      end
      // upper bits held at zero; software is still told to mask them
      stat_cap_d = '0;
      stat_cap_d[STAT_SYNC_BIT] = late_sync;
      stat_cap_d[STAT_BLANK_BIT] = late_blank_n;
      stat_cap_d[STAT_PLL_BIT] = pll_current_status;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dac_cap_q <= DAC_CAP_RST;
      stat_cap_q <= STAT_CAP_RST;
    end else begin
      dac_cap_q <= dac_cap_d;
      stat_cap_q <= stat_cap_d;
    end
  end

  // host port: strobe and select pass three flops, a change counts when stages 2 and 3 agree
  logic rd_s1_q, rd_s2_q, rd_s3_q, rd_lvl_q, rd_lvl_d;
  logic [1:0] sel_s1_q, sel_s2_q, sel_s3_q;
  logic rd_event;

  always_comb begin
    rd_lvl_d = rd_lvl_q;
    if (rd_s2_q == rd_s3_q) begin
      rd_lvl_d = rd_s3_q;
    end
    rd_event = rd_lvl_d & ~rd_lvl_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_s1_q <= 1'b0;
      rd_s2_q <= 1'b0;
      rd_s3_q <= 1'b0;
      rd_lvl_q <= 1'b0;
      sel_s1_q <= 2'h0;
      sel_s2_q <= 2'h0;
      sel_s3_q <= 2'h0;
    end else begin
      rd_s1_q <= ~host_rd_n;
      rd_s2_q <= rd_s1_q;
      rd_s3_q <= rd_s2_q;
      rd_lvl_q <= rd_lvl_d;
      sel_s1_q <= host_sel;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
    end
  end

  // read sequencer: successive reads walk red, green, blue; a new select restarts at red
  ptc_phase_e phase_q, phase_d;
  logic [1:0] last_sel_q, last_sel_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;
  ptc_phase_e ph;

  always_comb begin
    phase_d = phase_q;
    last_sel_d = last_sel_q;
    rd_data_d = rd_data_q;
    rd_valid_d = 1'b0;
    ph = (sel_s3_q == last_sel_q) ? phase_q : PH_RED_LO;
    if (rd_event) begin
      last_sel_d = sel_s3_q;
      rd_valid_d = 1'b1;
      rd_data_d = 8'h00;
      case (sel_s3_q)
        SEL_PIX: begin
          case (ph)
            PH_RED_LO: begin
              rd_data_d = pix_cap_q[23:16];
              phase_d = PH_GRN_LO;
            end
            PH_GRN_LO: begin
              rd_data_d = pix_cap_q[15:8];
              phase_d = PH_BLU_LO;
            end
            default: begin
              rd_data_d = pix_cap_q[7:0];
              phase_d = PH_RED_LO;
            end
          endcase
        end
        SEL_DAC: begin
          // eight-bit mode: three reads of low bytes; ten-bit: low then high per colour
          case (ph)
            PH_RED_LO: begin
              rd_data_d = dac_byte(dac_cap_q[29:20], 1'b0);
              phase_d = res_10bit ? PH_RED_HI : PH_GRN_LO;
            end
            PH_RED_HI: begin
              rd_data_d = dac_byte(dac_cap_q[29:20], 1'b1);
              phase_d = PH_GRN_LO;
            end
            PH_GRN_LO: begin
              rd_data_d = dac_byte(dac_cap_q[19:10], 1'b0);
              phase_d = res_10bit ? PH_GRN_HI : PH_BLU_LO;
            end
            PH_GRN_HI: begin
              rd_data_d = dac_byte(dac_cap_q[19:10], 1'b1);
              phase_d = PH_BLU_LO;
            end
            PH_BLU_LO: begin
              rd_data_d = dac_byte(dac_cap_q[9:0], 1'b0);
              phase_d = res_10bit ? PH_BLU_HI : PH_RED_LO;
            end
            default: begin
              rd_data_d = dac_byte(dac_cap_q[9:0], 1'b1);
              phase_d = PH_RED_LO;
            end
          endcase
        end
        SEL_STAT: begin
          rd_data_d = stat_cap_q;
          phase_d = PH_RED_LO;
        end
        default: begin
          rd_data_d = 8'h00;
          phase_d = PH_RED_LO;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_q <= PH_RED_LO;
      last_sel_q <= SEL_PIX;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      last_sel_q <= last_sel_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign host_rd_data = rd_data_q;
  assign host_rd_valid = rd_valid_q;

endmodule

/* tb/ptc_palette_model.sv */
// palette stand-in: returns a post-palette value a fixed number of clocks after issue
// assumes pal_* come from ptc_top on clk and dac_* are sampled by ptc_top
module ptc_palette_model
  import ptc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pal_valid,
  input wire logic [COLOR_W-1:0] pal_red,
  input wire logic [COLOR_W-1:0] pal_green,
  input wire logic [COLOR_W-1:0] pal_blue,
  output logic [DAC_W-1:0] dac_red,
  output logic [DAC_W-1:0] dac_green,
  output logic [DAC_W-1:0] dac_blue
);
  timeunit 1ns;
  timeprecision 1ps;
  // one stage per clock from the first edge that sees pal_valid up to the capture edge
  logic [3*COLOR_W:0] pipe_q [DAC_LATENCY];
  logic [3*COLOR_W:0] out_w;
  always_ff @(posedge clk) begin
    pipe_q[0] <= sys_rst ? '0 : {pal_valid, pal_red, pal_green, pal_blue};
    for (int i = 1; i < DAC_LATENCY; i++) begin
      pipe_q[i] <= pipe_q[i-1];
    end
  end
  assign out_w = pipe_q[DAC_LATENCY-1];
  // value is {idx[1:0], idx} so the upper dac bits carry data
  // outside the sampling slot the lines show the inverse, so a mistimed sample is caught
  always_comb begin
    dac_red = {out_w[17:16], out_w[23:16]};
    dac_green = {out_w[9:8], out_w[15:8]};
    dac_blue = {out_w[1:0], out_w[7:0]};
    if (!out_w[24]) begin
      dac_red = ~dac_red;
      dac_green = ~dac_green;
      dac_blue = ~dac_blue;
    end
  end
endmodule

/* tb/ptc_top_asserts.sv */
// port-level checks for ptc_top
// assumes one clock and synchronous active-high reset; attached by bind
module ptc_top_asserts
  import ptc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pipe_stall,
  input wire logic pal_valid,
  input wire logic [COLOR_W-1:0] pal_red,
  input wire logic [COLOR_W-1:0] pal_green,
  input wire logic [COLOR_W-1:0] pal_blue,
  input wire logic host_rd_n,
  input wire logic [1:0] host_sel,
  input wire logic [7:0] host_rd_data,
  input wire logic host_rd_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_strobe;
    $fell(host_rd_n);
  endsequence
  // slack around the sync latency since the strobe is treated as async
  sequence s_answer;
    ##[2:7] host_rd_valid;
  endsequence
  property p_rd_answer;
    s_strobe |-> s_answer;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read strobe not answered");
  property p_rd_pulse;
    host_rd_valid |=> !host_rd_valid;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid not one cycle");
  property p_rd_cause;
    host_rd_valid |-> $past(host_rd_n, 3) == 1'b0;
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read valid without strobe");
  property p_rd_hold;
    !host_rd_valid |-> $stable(host_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_stat_mask;
    host_rd_valid && host_sel == SEL_STAT |-> host_rd_data[7:3] == 5'h00;
  endproperty
  a_stat_mask: assert property (p_stat_mask) else $error("status upper bits set");
  property p_sel_idle;
    host_rd_valid && host_sel == 2'h3 |-> host_rd_data == 8'h00;
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("unused select not zero");
  property p_stall;
    pipe_stall |=> !pal_valid;
  endproperty
  a_stall: assert property (p_stall) else $error("pixel issued under stall");
  property p_pal_hold;
    !pal_valid |-> $stable({pal_red, pal_green, pal_blue});
  endproperty
  a_pal_hold: assert property (p_pal_hold) else $error("palette index moved");
endmodule

/* tb/tb_top.sv */
// self-checking bench for ptc_top with a palette stand-in
// assumes the bench acts as pixel source and host
module tb_top;
  import ptc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, trigger_polarity_select = 1'b1, res_10bit = 1'b1;
  logic pix_valid = 1'b0, pix_sync = 1'b0, pix_blank_n = 1'b1, pipe_stall = 1'b0;
  logic pll_current_status = 1'b0, host_rd_n = 1'b1;
  logic [COLOR_W-1:0] pix_red = 8'h00, pix_green = 8'h00, pix_blue = 8'h00;
  logic [1:0] host_sel = 2'h0;
  logic pix_ready, pal_valid, host_rd_valid;
  logic [COLOR_W-1:0] pal_red, pal_green, pal_blue;
  logic [DAC_W-1:0] dac_red, dac_green, dac_blue;
  logic [7:0] host_rd_data;
  int failures = 0;
  int compares = 0;
  ptc_top u_ptc_top (.clk, .sys_rst, .trigger_polarity_select, .res_10bit, .pix_valid,
    .pix_ready, .pix_red, .pix_green, .pix_blue, .pix_sync, .pix_blank_n, .pipe_stall,
    .pal_valid, .pal_red, .pal_green, .pal_blue, .dac_red, .dac_green, .dac_blue,
    .pll_current_status, .host_rd_n, .host_sel, .host_rd_data, .host_rd_valid);
  ptc_palette_model u_ptc_palette_model (.clk, .sys_rst, .pal_valid, .pal_red, .pal_green,
    .pal_blue, .dac_red, .dac_green, .dac_blue);
  always #2.5 clk = ~clk;
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic timeout();
    failures++;
    summarize();
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // leaves pix_valid high so pixels can go back to back; caller lowers it
  task automatic put_pix(input logic [7:0] r, g, b, input logic s, bn);
    int n = 0;
    {pix_red, pix_green, pix_blue, pix_sync, pix_blank_n, pix_valid} <= {r, g, b, s, bn, 1'b1};
    do begin
      @(negedge clk);
      n++;
    end while (pix_ready !== 1'b1 && n < 50);
    if (n >= 50) timeout();
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [1:0] sel, input logic [7:0] exp);
    int n = 0;
    @(posedge clk);
    {host_sel, host_rd_n} <= {sel, 1'b0};
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (host_rd_valid !== 1'b1 && n < 20);
    if (n >= 20) timeout();
    chk8(host_rd_data, exp);
    @(posedge clk);
    host_rd_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic s_rise();
    logic [7:0] d [6] = '{8'h95, 8'h01, 8'h3C, 8'h00, 8'hA7, 8'h03};
    {trigger_polarity_select, res_10bit, pll_current_status} <= 3'b111;
    put_pix(8'h10, 8'h01, 8'h02, 1'b0, 1'b1);
    put_pix(8'h95, 8'h3C, 8'hA7, 1'b1, 1'b1);
    put_pix(8'h05, 8'h66, 8'h77, 1'b0, 1'b1);
    pix_valid <= 1'b0;
    repeat (12) @(posedge clk);
    rd_chk(SEL_PIX, 8'h95);
    rd_chk(SEL_PIX, 8'h3C);
    rd_chk(SEL_PIX, 8'hA7);
    foreach (d[i]) rd_chk(SEL_DAC, d[i]);
    rd_chk(SEL_STAT, 8'h07);
    rd_chk(2'h3, 8'h00);
  endtask
  task automatic s_fall();
    {trigger_polarity_select, res_10bit, pll_current_status} <= 3'b000;
    put_pix(8'hC2, 8'h01, 8'h02, 1'b0, 1'b1);
    put_pix(8'h42, 8'h11, 8'h99, 1'b1, 1'b0);
    put_pix(8'hC0, 8'h55, 8'h66, 1'b0, 1'b1);
    pix_valid <= 1'b0;
    repeat (12) @(posedge clk);
    rd_chk(SEL_PIX, 8'h42);
    rd_chk(SEL_PIX, 8'h11);
    rd_chk(SEL_PIX, 8'h99);
    repeat (3) rd_chk(SEL_DAC, 8'h00);
    rd_chk(SEL_STAT, 8'h01);
  endtask
  // fill under stall until refused, then drain; rising polarity so no trigger occurs
  task automatic s_fifo();
    int n = 0;
    int k = 0;
    {trigger_polarity_select, pipe_stall} <= 2'b11;
    {pix_red, pix_green, pix_blue, pix_valid} <= {24'h000000, 1'b1};
    repeat (20) begin
      @(negedge clk);
      if (pix_ready === 1'b1) n++;
    end
    @(posedge clk);
    pix_valid <= 1'b0;
    chk32(n, FIFO_DEPTH);
    pipe_stall <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (pal_valid === 1'b1) k++;
    end
    chk32(k, FIFO_DEPTH);
    rd_chk(SEL_PIX, 8'h42);
  endtask
  // capture in eight-bit mode, read back in ten-bit order so the upper bits show
  task automatic s_eight();
    logic [7:0] d [6] = '{8'h8B, 8'h00, 8'h5E, 8'h00, 8'hC1, 8'h00};
    {trigger_polarity_select, res_10bit, pll_current_status} <= 3'b100;
    put_pix(8'h8B, 8'h5E, 8'hC1, 1'b0, 1'b1);
    pix_valid <= 1'b0;
    repeat (12) @(posedge clk);
    res_10bit <= 1'b1;
    foreach (d[i]) rd_chk(SEL_DAC, d[i]);
    rd_chk(SEL_STAT, 8'h02);
    rd_chk(SEL_PIX, 8'h8B);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk8(host_rd_data, 8'h00);
    @(posedge clk);
    s_rise();
    s_fall();
    s_fifo();
    s_eight();
    summarize();
  end
endmodule
bind ptc_top ptc_top_asserts u_ptc_top_asserts (.clk, .sys_rst, .pipe_stall, .pal_valid,
  .pal_red, .pal_green, .pal_blue, .host_rd_n, .host_sel, .host_rd_data, .host_rd_valid);
